// ### rtl/sample_buffer_pkg.sv
// constants and carrier types for the sample buffer control block
// assumes an 8-bit register port driven by the serial interface front end
package sample_buffer_pkg;
	localparam logic [7:0] BUFFER_CONFIG_TWO_ADDR = 8'h27;
	localparam logic [7:0] BUFFER_CONFIG_TWO_RESET = 8'h00;
	localparam int FLUSH_BIT = 7;
	localparam int HOLD_AWAKE_BIT = 6;
	localparam int THRESHOLD_MSB = 5;
	localparam int THRESHOLD_W = 6;
	localparam int COUNT_W = 6;
	localparam logic [COUNT_W-1:0] BUFFER_DEPTH = 6'h20;
	localparam int SLEEP_W = 8;

	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_STREAM = 2'h1,
		MODE_STOP = 2'h2,
		MODE_TRIGGER = 2'h3
	} buf_mode_t;

	typedef enum logic [2:0] {
		TRIG_ARMED = 3'h1,
		TRIG_COLLECT = 3'h2,
		TRIG_DONE = 3'h4
	} trig_state_t;

	typedef struct packed {
		logic flush;
		logic hold_awake;
		logic [THRESHOLD_W-1:0] threshold;
	} cfg_t;
endpackage

// ### rtl/auto_sleep_timer.sv
// auto-sleep timer: counts output-data ticks while awake, sleeps at the period
// assumes i_tick is a one-cycle pulse per sample period
`timescale 1ns/10ps
`default_nettype none
module auto_sleep_timer
	import sample_buffer_pkg::*;
#(
	parameter int WIDTH = SLEEP_W
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_tick,
	input wire logic i_restart,
	input wire logic i_hold,
	input wire logic [WIDTH-1:0] i_period,
	output logic o_asleep
);
	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_inc;
	logic run;

	assign count_inc = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
	// a zero period leaves auto-sleep off
	assign run = !o_asleep && (i_period != '0) && i_tick;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count_r <= '0;
			o_asleep <= 1'b0;
		end else if (i_restart || i_hold) begin
			count_r <= '0;
			o_asleep <= 1'b0;
		end else if (run) begin
			count_r <= count_inc;
			o_asleep <= (count_inc >= i_period);
		end
	end
endmodule
`default_nettype wire

// ### rtl/sample_buffer_control.sv
// control of the output sample buffer: flush, fill threshold, trigger capture
// and the buffer's part in auto wake/sleep; storage itself sits outside and
// follows o_store, o_discard_oldest and o_flush one cycle after each request
//
// Contract
// - Writing 1 to bit 7 of the config register discards all samples and clears every buffer event flag.
// - A flush also clears the gate error flag and the gate sample count.
// - The flush bit clears itself within one cycle, so it always reads back 0.
// - With the keep-awake bit 0 (reset) the sleep logic ignores buffer flags; with 1 they count as activity.
// - With keep-awake set, flags left pending until the timer expires let the device sleep.
// - Clearing the flags by flush or sample read restarts the timer and keeps the device awake.
// - Keep-awake only acts in stream or stop mode.
// - A threshold of 0 disables the watermark flag.
// - In triggered mode the threshold caps the samples kept from before the trigger.
// - Mode 00b flushes the buffer and clears overrun, watermark and count.
// - After a trigger, later triggers are ignored, 32 minus threshold samples are taken, then overrun sets and capture stops until flush or empty.
// - Moving from standby to active or external-trigger mode flushes the buffer.
`timescale 1ns/10ps
`default_nettype none
module sample_buffer_control
	import sample_buffer_pkg::*;
#(
	parameter int SLEEP_PERIOD_W = SLEEP_W
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [1:0] i_buf_mode,
	input wire logic i_buf_gate,
	input wire logic i_sample_push,
	input wire logic i_sample_pop,
	input wire logic i_trigger,
	input wire logic i_standby_exit,
	input wire logic i_odr_tick,
	input wire logic i_wake_activity,
	input wire logic [SLEEP_PERIOD_W-1:0] i_auto_sleep_period,
	output logic [7:0] o_reg_rdata,
	output logic [COUNT_W-1:0] o_sample_count,
	output logic o_watermark_flag,
	output logic o_overrun_flag,
	output logic o_store,
	output logic o_discard_oldest,
	output logic o_flush,
	output logic o_gate_clear,
	output logic o_asleep
);
	cfg_t cfg_r;
	trig_state_t trig_r;
	trig_state_t trig_nxt;
	logic [COUNT_W-1:0] post_r;
	logic [COUNT_W-1:0] post_nxt;
	logic [COUNT_W-1:0] count_nxt;
	logic ovf_nxt;
	logic asleep_q;
	logic flags_q;

	function automatic logic [COUNT_W-1:0] inc(input logic [COUNT_W-1:0] v);
		return v + {{(COUNT_W-1){1'b0}}, 1'b1};
	endfunction

	function automatic logic [COUNT_W-1:0] dec(input logic [COUNT_W-1:0] v);
		return v - {{(COUNT_W-1){1'b0}}, 1'b1};
	endfunction

	// register port decode
	wire cfg_hit = (i_reg_addr == BUFFER_CONFIG_TWO_ADDR);
	wire cfg_wr = i_reg_wr && cfg_hit;
	wire [7:0] cfg_read = {1'b0, cfg_r.hold_awake, cfg_r.threshold};

	wire buf_mode_t mode = buf_mode_t'(i_buf_mode);
	wire mode_off = (mode == MODE_OFF);
	wire mode_trig = (mode == MODE_TRIGGER);
	wire hold_eff = cfg_r.hold_awake && (mode == MODE_STREAM || mode == MODE_STOP);

	// auto transitions flush unless gated; triggered mode ignores the gate
	wire sleep_edge = (o_asleep != asleep_q);
	wire auto_flush = sleep_edge && (!i_buf_gate || mode_trig);
	wire flush_now = cfg_r.flush || mode_off || i_standby_exit || auto_flush;

	wire full = (o_sample_count == BUFFER_DEPTH);
	wire empty = (o_sample_count == '0);
	wire pop_ok = i_sample_pop && !empty;
	wire [COUNT_W-1:0] post_goal = BUFFER_DEPTH - COUNT_W'(cfg_r.threshold);
	wire pre_full = (o_sample_count >= cfg_r.threshold);

	// storage decisions per mode
	wire stream_drop = (mode == MODE_STREAM) && full;
	wire stop_block = (mode == MODE_STOP) && (full || o_overrun_flag);
	wire trig_pre = mode_trig && (trig_r == TRIG_ARMED);
	wire trig_block = mode_trig && ((trig_r == TRIG_DONE) || (trig_pre && cfg_r.threshold == '0));
	wire trig_drop = trig_pre && pre_full && (cfg_r.threshold != '0);
	wire push_ok = i_sample_push && !flush_now && !stop_block && !trig_block;
	wire drop_ok = push_ok && (stream_drop || trig_drop);
	wire trig_fire = trig_pre && i_trigger;
	wire post_last = (trig_r == TRIG_COLLECT) && push_ok && (inc(post_r) >= post_goal);

	always_comb begin
		count_nxt = o_sample_count;
		if (flush_now) begin
			count_nxt = '0;
		end else if (push_ok && !drop_ok && !pop_ok) begin
			count_nxt = inc(o_sample_count);
		end else if (pop_ok && !(push_ok && !drop_ok)) begin
			count_nxt = dec(o_sample_count);
		end
	end

	always_comb begin
		trig_nxt = trig_r;
		post_nxt = post_r;
		case (trig_r)
			TRIG_ARMED: begin
				if (trig_fire && !flush_now) begin
					trig_nxt = TRIG_COLLECT;
					post_nxt = '0;
				end
			end
			TRIG_COLLECT: begin
				// further triggers are ignored here
				if (post_last) begin
					trig_nxt = TRIG_DONE;
				end else if (push_ok) begin
					post_nxt = inc(post_r);
				end
			end
			TRIG_DONE: begin
				if (count_nxt == '0) begin
					trig_nxt = TRIG_ARMED;
				end
			end
			default: begin
				trig_nxt = TRIG_ARMED;
			end
		endcase
		if (flush_now || !mode_trig) begin
			trig_nxt = TRIG_ARMED;
			post_nxt = '0;
		end
	end

	// overrun: stream or stop on a push into a full buffer, or end of capture
	always_comb begin
		ovf_nxt = o_overrun_flag;
		if (i_sample_push && !flush_now && (mode == MODE_STREAM || mode == MODE_STOP) && full) begin
			ovf_nxt = 1'b1;
		end else if (post_last) begin
			ovf_nxt = 1'b1;
		end else if (flush_now || pop_ok) begin
			ovf_nxt = 1'b0;
		end
	end

	wire wmrk_nxt = (cfg_r.threshold != '0) && !mode_trig &&
		(COUNT_W'(cfg_r.threshold) <= count_nxt) && !flush_now;
	wire flags_now = o_watermark_flag || o_overrun_flag;
	wire flags_cleared = flags_q && !flags_now;
	wire flags_raised = !flags_q && flags_now;
	// only edges of the flags matter; a flag left pending lets the timer run out
	wire timer_restart = i_wake_activity || trig_fire || (hold_eff && (flags_cleared || flags_raised));
	wire timer_hold = mode_trig && (trig_r != TRIG_ARMED);
	wire emptied = pop_ok && (o_sample_count == {{(COUNT_W-1){1'b0}}, 1'b1});

	auto_sleep_timer #(
		.WIDTH(SLEEP_PERIOD_W)
	) u_timer (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_tick(i_odr_tick),
		.i_restart(timer_restart),
		.i_hold(timer_hold),
		.i_period(i_auto_sleep_period),
		.o_asleep(o_asleep)
	);

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_r <= cfg_t'(BUFFER_CONFIG_TWO_RESET);
		end else if (cfg_wr) begin
			cfg_r <= cfg_t'(i_reg_wdata);
		end else begin
			cfg_r.flush <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			o_reg_rdata <= cfg_hit ? cfg_read : 8'h00;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sample_count <= '0;
			o_watermark_flag <= 1'b0;
			o_overrun_flag <= 1'b0;
			trig_r <= TRIG_ARMED;
			post_r <= '0;
			asleep_q <= 1'b0;
			flags_q <= 1'b0;
		end else begin
			o_sample_count <= count_nxt;
			o_watermark_flag <= wmrk_nxt;
			o_overrun_flag <= ovf_nxt;
			trig_r <= trig_nxt;
			post_r <= post_nxt;
			asleep_q <= o_asleep;
			flags_q <= flags_now;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_store <= 1'b0;
			o_discard_oldest <= 1'b0;
			o_flush <= 1'b0;
			o_gate_clear <= 1'b0;
		end else begin
			o_store <= push_ok;
			o_discard_oldest <= drop_ok;
			o_flush <= flush_now;
			o_gate_clear <= flush_now || emptied;
		end
	end
endmodule
`default_nettype wire

// ### bench/sample_buffer_monitor.sv
// assertions on the sample buffer control ports
// bound into every instance of the block
`timescale 1ns/10ps
`default_nettype none
module sample_buffer_monitor
	import sample_buffer_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [1:0] i_buf_mode,
	input wire logic i_sample_push,
	input wire logic i_standby_exit,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [COUNT_W-1:0] o_sample_count,
	input wire logic o_watermark_flag,
	input wire logic o_overrun_flag,
	input wire logic o_flush,
	input wire logic o_gate_clear
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	wire logic wr_flush = i_reg_wr && i_reg_addr == BUFFER_CONFIG_TWO_ADDR && i_reg_wdata[FLUSH_BIT];
	property p_flush; wr_flush |-> ##2 (o_flush && o_sample_count == '0 && !o_overrun_flag && !o_watermark_flag); endproperty
	a_flush: assert property (p_flush) else $error("flush left data");
	property p_gate; wr_flush |-> ##2 o_gate_clear; endproperty
	a_gate: assert property (p_gate) else $error("gate not cleared");
	property p_rd7; o_reg_rdata[FLUSH_BIT] == 1'b0; endproperty
	a_rd7: assert property (p_rd7) else $error("flush bit read high");
	property p_wm; o_watermark_flag |-> o_sample_count != '0; endproperty
	a_wm: assert property (p_wm) else $error("watermark on empty");
	property p_off; (i_buf_mode == MODE_OFF) [*2] |=> (o_sample_count == '0 && !o_overrun_flag); endproperty
	a_off: assert property (p_off) else $error("off mode kept data");
	property p_sby; i_standby_exit |=> o_flush; endproperty
	a_sby: assert property (p_sby) else $error("no flush on start");
	property p_race; i_standby_exit && i_sample_push |-> ##[1:2] o_sample_count == '0; endproperty
	a_race: assert property (p_race) else $error("push beat flush");
	property p_depth; o_sample_count <= BUFFER_DEPTH; endproperty
	a_depth: assert property (p_depth) else $error("count past depth");
endmodule
bind sample_buffer_control sample_buffer_monitor sample_buffer_monitor_inst (.*);
`default_nettype wire

// ### bench/host_port.sv
// host side of the register port: single-byte writes and reads
// drives after falling edges; read data taken the cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module host_port (
	input wire logic i_clock,
	input wire logic [7:0] i_rdata,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge i_clock);
		{o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
		@(negedge i_clock);
		// released data lines show the inverse, not the old value
		{o_wr, o_rd, o_wdata} = {2'b00, ~d};
		q = i_rdata;
	endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for sample_buffer_control with a counting reference
// assumes host_port drives the register port; gate held at 1
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sample_buffer_pkg::*;
	logic clk = 0, rst_b = 0, wr, rd, push = 0, pop = 0, trig = 0, sbx = 0, wake = 0, wm, ovf, gc, asl, st, dc;
	logic [1:0] mode = MODE_STREAM;
	logic [7:0] addr, wdata, rdata, q, per = 0;
	logic [5:0] cnt_o;
	int err_count = 0, n_compared = 0, cnt = 0, thr = 0, cap = 32, blk = 0, seed = 66626;
	always #12.5 clk = ~clk;
	sample_buffer_control sample_buffer_control_inst (.i_clock(clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_buf_mode(mode), .i_buf_gate(1'b1), .i_sample_push(push),
		.i_sample_pop(pop), .i_trigger(trig), .i_standby_exit(sbx), .i_odr_tick(1'b1), .i_wake_activity(wake),
		.i_auto_sleep_period(per), .o_reg_rdata(rdata), .o_sample_count(cnt_o), .o_watermark_flag(wm),
		.o_overrun_flag(ovf), .o_store(st), .o_discard_oldest(dc), .o_flush(), .o_gate_clear(gc), .o_asleep(asl));
	host_port host_port_inst (.i_clock(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	task automatic chk(input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rw(input logic w, input logic [7:0] a, d);
		host_port_inst.xfer(w, a, d, q);
	endtask
	task automatic step(input logic up, input int n);
		repeat (n) begin
			@(negedge clk);
			{push, pop} = {up, !up};
			@(negedge clk);
			{push, pop} = 2'b00;
			// at the cap a push is either refused (blk) or stored over the oldest
			chk(8'(st), 8'(up && !(blk != 0 && cnt >= cap)));
			chk(8'(dc), 8'(up && blk == 0 && cnt >= cap));
			cnt = up ? (cnt < cap ? cnt + 1 : cnt) : (cnt > 0 ? cnt - 1 : 0);
			chk(8'(cnt_o), 8'(cnt));
			chk(8'(wm), 8'(thr != 0 && cnt >= thr && mode != MODE_TRIGGER));
		end
	endtask
	task automatic pulse_wake;
		@(negedge clk);
		wake = 1;
		@(negedge clk);
		wake = 0;
	endtask
	task automatic complete_run;
		$display("compared=%0d mismatches=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst_b = 1;
		rw(0, 8'h27, 8'h00);
		chk(q, BUFFER_CONFIG_TWO_RESET);
		rw(1, 8'h2A, 8'hFF);
		rw(0, 8'h2A, 8'h00);
		chk(q, 8'h00);
		thr = 4;
		rw(1, 8'h27, 8'h44);
		rw(0, 8'h27, 8'h00);
		chk(q, 8'h44);
		step(1, 1 + $unsigned($random(seed)) % 20);
		step(0, 2);
		rw(1, 8'h27, 8'h84);
		@(negedge clk);
		chk(8'(gc), 8'h01);
		cnt = 0;
		chk(8'(cnt_o), 8'h00);
		rw(0, 8'h27, 8'h00);
		chk(q, 8'h04);
		step(1, 33);
		chk(8'(ovf), 8'h01);
		@(negedge clk);
		{push, sbx} = 2'b11;
		@(negedge clk);
		{push, sbx} = 2'b00;
		repeat (2) @(negedge clk);
		cnt = 0;
		chk(8'(cnt_o), 8'h00);
		chk(8'(ovf), 8'h00);
		thr = 0;
		rw(1, 8'h27, 8'h00);
		step(1, 3);
		mode = MODE_OFF;
		repeat (3) @(negedge clk);
		cnt = 0;
		chk(8'(cnt_o), 8'h00);
		{mode, thr, cap} = {MODE_TRIGGER, 32'd2, 32'd2};
		rw(1, 8'h27, 8'h02);
		step(1, 5);
		trig = 1;
		@(negedge clk);
		trig = 0;
		{cap, blk} = {32'd32, 32'd1};
		step(1, 35);
		chk(8'(ovf), 8'h01);
		// stop mode: full or overrun refuses pushes, a pop reopens one slot
		mode = MODE_STOP;
		step(1, 2);
		step(0, 1);
		step(1, 2);
		blk = 0;
		{mode, per, thr, cnt} = {MODE_STREAM, 8'h06, 32'd1, 32'd0};
		rw(1, 8'h27, 8'hC1);
		pulse_wake();
		repeat (2) @(negedge clk);
		repeat (8) begin
			step(1, 1);
			step(0, 1);
			chk(8'(asl), 8'h00);
		end
		step(1, 1);
		// bounded wait: a missing sleep shows up as one mismatch
		repeat (60) if (asl !== 1'b1) @(negedge clk);
		chk(8'(asl), 8'h01);
		pulse_wake();
		rw(1, 8'h27, 8'h01);
		repeat (6) begin
			step(0, 1);
			step(1, 1);
		end
		chk(8'(asl), 8'h01);
		complete_run();
	end
endmodule
`default_nettype wire
